/* hdl/sacr_pkg.sv */
// Package: offsets, field positions, reset values and frame layout
// for the synthesizer auxiliary configuration register bank.
// Assumes a 32-bit serial frame: R/W flag, 4-bit address, 27-bit data.
package sacr_pkg;
  localparam int REG_W = 27;
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 5;
  localparam logic [5:0] FRAME_BITS_C = 6'h20;
  localparam logic [5:0] HDR_BITS_C = 6'h05;
  // Register addresses (frame address field)
  localparam logic [3:0] ADDR_FAST_LOCK_PIN = 4'h7;
  localparam logic [3:0] ADDR_REG_SETTINGS = 4'h8;
  localparam logic [3:0] ADDR_TEST_INIT = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'hA;
  // Reset values
  localparam logic [26:0] FAST_LOCK_PIN_RST = 27'h0000000;
  localparam logic [26:0] REG_SETTINGS_RST = 27'h0000000;
  localparam logic [26:0] TEST_INIT_RST = 27'h0000000;
  // Fast-lock / pin control fields
  localparam int FL_PIN_HIZ = 25;
  localparam int FL_DRIVE_STYLE = 24;
  localparam int FL_READ_SWITCH_OFF = 23;
  localparam int FL_SRC_SEL_HI = 22;
  localparam int FL_SRC_SEL_LO = 21;
  localparam int FL_DIG_OCP_OFF = 20;
  localparam int FL_CYCLE_SLIP = 19;
  localparam int FL_QUICK_ON = 18;
  localparam int FL_PUMP_HI = 17;
  localparam int FL_PUMP_LO = 13;
  localparam int FL_CYCLES_HI = 12;
  localparam int FL_CYCLES_LO = 0;
  // Regulator settings fields
  localparam int RS_OUT2_OVERRIDE = 26;
  localparam int RS_REGS_OCP_OFF = 19;
  localparam int RS_DIG_DOWN = 18;
  localparam int RS_DIG_V_HI = 17;
  localparam int RS_DIG_V_LO = 16;
  localparam int RS_REF_DOWN = 14;
  localparam int RS_REF_V_HI = 13;
  localparam int RS_REF_V_LO = 12;
  localparam int RS_RF_DOWN = 10;
  localparam int RS_RF_V_HI = 9;
  localparam int RS_RF_V_LO = 8;
  localparam int RS_OSC_DOWN = 6;
  localparam int RS_OSC_V_HI = 5;
  localparam int RS_OSC_V_LO = 4;
  localparam int RS_HV_DOWN = 2;
  localparam int RS_HV_V_HI = 1;
  localparam int RS_HV_V_LO = 0;
  // Lock pin source codes
  localparam logic [1:0] SRC_LOCK = 2'h0;
  localparam logic [1:0] SRC_LOOP_DIV = 2'h1;
  localparam logic [1:0] SRC_CAL_DIV = 2'h2;
  localparam logic [1:0] SRC_QUICK_CLK = 2'h3;
  // Serial frame states, Gray along idle -> header -> data
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_HEADER = 2'b01,
    SER_DATA = 2'b11
  } sacr_ser_state_type;
endpackage

/* hdl/sacr_quick_settle.sv */
// Fast-lock slot timer: counts phase-detector cycles after a start pulse.
// Assumes pfd_tick_i is a one-cycle enable at the phase-detector rate.
`timescale 1ns/1ns
module sacr_quick_settle
  import sacr_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Control
  input wire logic enable_i,
  input wire logic start_i,
  input wire logic pfd_tick_i,
  input wire logic [12:0] cycles_i,
  // Status
  output logic active_o
);
  logic [12:0] count_r;
  logic active_r;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      count_r <= 13'h0000;
      active_r <= 1'b0;
    end else if (!enable_i) begin
      count_r <= 13'h0000;
      active_r <= 1'b0;
    end else if (start_i) begin
      count_r <= 13'h0000;
      active_r <= 1'b1;
    end else if (active_r && pfd_tick_i) begin
      // Slot closes after cycles_i phase-detector ticks, or after one tick when cycles_i is 0
      if (count_r + 13'h0001 >= cycles_i) begin
        active_r <= 1'b0;
      end
      count_r <= count_r + 13'h0001;
    end
  end

  assign active_o = active_r;
endmodule

/* hdl/sacr_regs.sv */
// Auxiliary configuration register bank with serial port and lock pin.
// Assumes serial pins are synchronous to mclk_i and far slower than it.
`timescale 1ns/1ns
module sacr_regs
  import sacr_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Serial port
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_load_i,
  // Lock / serial-out pin
  output logic lock_serial_out_pin_o,
  output logic lock_serial_out_pin_oe_o,
  output logic lock_pin_push_pull_o,
  // Loop inputs
  input wire logic lock_det_i,
  input wire logic loop_div_i,
  input wire logic cal_div_i,
  input wire logic pfd_tick_i,
  input wire logic quick_settle_start_i,
  input wire logic [4:0] normal_pump_current_i,
  // Regulator and calibrator status
  input wire logic [4:0] reg_startup_i,
  input wire logic [4:0] reg_overcurrent_i,
  input wire logic [1:0] vco_sel_i,
  input wire logic [4:0] vco_word_i,
  // Power-down pins
  input wire logic out1_down_pin_i,
  input wire logic out2_down_or_filter_switch_pin_i,
  output logic out1_down_o,
  output logic out2_down_o,
  output logic filter_switch_o,
  // Loop controls
  output logic cycle_slip_on_o,
  output logic [4:0] pump_current_o,
  output logic quick_settle_active_o,
  // Regulator controls and test/init word
  output logic digital_reg_overcurrent_off_o,
  output logic regs_overcurrent_off_o,
  output logic [4:0] reg_down_o,
  output logic [1:0] digital_reg_voltage_o,
  output logic [1:0] refclk_reg_voltage_o,
  output logic [1:0] rfout_reg_voltage_o,
  output logic [1:0] osc_bias_reg_voltage_o,
  output logic [1:0] high_volt_reg_voltage_o,
  output logic [26:0] test_init_o
);
  logic [26:0] fast_lock_pin_control_r;
  logic [26:0] regulator_settings_r;
  logic [26:0] test_init_reserved_r;
  logic [26:0] status_word;
  sacr_ser_state_type ser_state_r;
  logic ser_clk_d_r;
  logic ser_load_d_r;
  logic [31:0] shift_in_r;
  logic [5:0] bit_cnt_r;
  logic [26:0] shift_out_r;
  logic read_frame_r;
  logic sdo_r;
  logic slot_active;
  logic [1:0] src_sel;
  logic src_level;
  logic pin_level;
  logic reading;
  logic pin_o_r;
  logic pin_oe_r;
  logic pp_r;
  logic out1_r;
  logic out2_r;
  logic fsw_r;
  logic slip_r;
  logic [4:0] pump_r;
  logic qs_r;

  wire ser_rise = ser_clk_i && !ser_clk_d_r;
  wire ser_fall = !ser_clk_i && ser_clk_d_r;
  wire load_rise = ser_load_i && !ser_load_d_r;

  function automatic logic [26:0] read_mux(input logic [3:0] addr,
                                           input logic [26:0] fl,
                                           input logic [26:0] rs,
                                           input logic [26:0] ti,
                                           input logic [26:0] st);
    unique case (addr)
      ADDR_FAST_LOCK_PIN: read_mux = fl;
      ADDR_REG_SETTINGS: read_mux = rs;
      ADDR_TEST_INIT: read_mux = ti;
      ADDR_STATUS: read_mux = st;
      default: read_mux = 27'h0000000;
    endcase
  endfunction

  // Status layout; unused upper bits read zero
  assign status_word = {9'h000, reg_startup_i, reg_overcurrent_i, lock_det_i,
                        vco_sel_i, vco_word_i};

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ser_clk_d_r <= 1'b0;
      ser_load_d_r <= 1'b1; // Idle level of load, so no false edge after reset
    end else begin
      ser_clk_d_r <= ser_clk_i;
      ser_load_d_r <= ser_load_i;
    end
  end

  // Frame runs while load is low; bits shift in MSB first on rising clock
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ser_state_r <= SER_IDLE;
      shift_in_r <= 32'h00000000;
      bit_cnt_r <= 6'h00;
      read_frame_r <= 1'b0;
    end else if (ser_load_i) begin
      ser_state_r <= SER_IDLE;
      bit_cnt_r <= 6'h00;
      read_frame_r <= 1'b0;
    end else begin
      unique case (ser_state_r)
        SER_IDLE: begin
          shift_in_r <= 32'h00000000;
          ser_state_r <= SER_HEADER;
        end
        SER_HEADER: begin
          if (ser_rise) begin
            shift_in_r <= {shift_in_r[30:0], ser_data_i};
            bit_cnt_r <= bit_cnt_r + 6'h01;
            if (bit_cnt_r + 6'h01 == HDR_BITS_C) begin
              ser_state_r <= SER_DATA;
              read_frame_r <= shift_in_r[3];
            end
          end
        end
        SER_DATA: begin
          if (ser_rise && bit_cnt_r != FRAME_BITS_C) begin
            shift_in_r <= {shift_in_r[30:0], ser_data_i};
            bit_cnt_r <= bit_cnt_r + 6'h01;
          end
        end
      endcase
    end
  end

  // Read data: word loaded once the header is in, bits leave on falling clock
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      shift_out_r <= 27'h0000000;
      sdo_r <= 1'b0;
    end else if (ser_state_r == SER_HEADER && ser_rise &&
                 bit_cnt_r + 6'h01 == HDR_BITS_C) begin
      shift_out_r <= read_mux({shift_in_r[2:0], ser_data_i},
                              fast_lock_pin_control_r, regulator_settings_r,
                              test_init_reserved_r, status_word);
    end else if (ser_state_r == SER_DATA && read_frame_r && ser_fall) begin
      sdo_r <= shift_out_r[26];
      shift_out_r <= {shift_out_r[25:0], 1'b0};
    end
  end

  // Writes commit on load rise after a full frame; status has no store
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      fast_lock_pin_control_r <= FAST_LOCK_PIN_RST;
      regulator_settings_r <= REG_SETTINGS_RST;
      test_init_reserved_r <= TEST_INIT_RST;
    end else if (load_rise && bit_cnt_r == FRAME_BITS_C && !shift_in_r[31]) begin
      unique case (shift_in_r[30:27])
        ADDR_FAST_LOCK_PIN: fast_lock_pin_control_r <= shift_in_r[26:0];
        ADDR_REG_SETTINGS: regulator_settings_r <= shift_in_r[26:0];
        ADDR_TEST_INIT: test_init_reserved_r <= shift_in_r[26:0];
        default: ;
      endcase
    end
  end

  sacr_quick_settle u_quick_settle (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .enable_i(fast_lock_pin_control_r[FL_QUICK_ON]),
    .start_i(quick_settle_start_i),
    .pfd_tick_i(pfd_tick_i),
    .cycles_i(fast_lock_pin_control_r[FL_CYCLES_HI:FL_CYCLES_LO]),
    .active_o(slot_active)
  );

  assign src_sel = fast_lock_pin_control_r[FL_SRC_SEL_HI:FL_SRC_SEL_LO];

  // Lock pin source multiplexer
  always_comb begin
    unique case (src_sel)
      SRC_LOCK: src_level = lock_det_i;
      SRC_LOOP_DIV: src_level = loop_div_i;
      SRC_CAL_DIV: src_level = cal_div_i;
      SRC_QUICK_CLK: src_level = pfd_tick_i;
    endcase
  end

  // Pin carries read data only when auto-switch is allowed
  assign reading = read_frame_r && ser_state_r == SER_DATA &&
                   !fast_lock_pin_control_r[FL_READ_SWITCH_OFF];
  assign pin_level = reading ? sdo_r : src_level;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pin_o_r <= 1'b0;
      pin_oe_r <= 1'b0;
      pp_r <= 1'b0;
    end else begin
      pp_r <= fast_lock_pin_control_r[FL_DRIVE_STYLE];
      if (fast_lock_pin_control_r[FL_PIN_HIZ]) begin
        pin_o_r <= 1'b0;
        pin_oe_r <= 1'b0;
      end else if (fast_lock_pin_control_r[FL_DRIVE_STYLE]) begin
        pin_o_r <= pin_level;
        pin_oe_r <= 1'b1;
      end else begin
        // Open drain only pulls low; high comes from the external pull-up
        pin_o_r <= 1'b0;
        pin_oe_r <= !pin_level;
      end
    end
  end

  // Power-down pins, filter switch, pump current
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      out1_r <= 1'b0;
      out2_r <= 1'b0;
      fsw_r <= 1'b0;
      slip_r <= 1'b0;
      pump_r <= 5'h00;
      qs_r <= 1'b0;
    end else begin
      out1_r <= out1_down_pin_i;
      if (regulator_settings_r[RS_OUT2_OVERRIDE]) begin
        out2_r <= out1_down_pin_i;
      end else if (fast_lock_pin_control_r[FL_QUICK_ON]) begin
        // Shared pin is the filter switch, so it no longer powers down out2
        out2_r <= 1'b0;
      end else begin
        out2_r <= out2_down_or_filter_switch_pin_i;
      end
      fsw_r <= fast_lock_pin_control_r[FL_QUICK_ON] && slot_active;
      slip_r <= fast_lock_pin_control_r[FL_CYCLE_SLIP];
      pump_r <= slot_active ? fast_lock_pin_control_r[FL_PUMP_HI:FL_PUMP_LO]
                            : normal_pump_current_i;
      qs_r <= slot_active;
    end
  end

  assign lock_serial_out_pin_o = pin_o_r;
  assign lock_serial_out_pin_oe_o = pin_oe_r;
  assign lock_pin_push_pull_o = pp_r;
  assign out1_down_o = out1_r;
  assign out2_down_o = out2_r;
  assign filter_switch_o = fsw_r;
  assign cycle_slip_on_o = slip_r;
  assign pump_current_o = pump_r;
  assign quick_settle_active_o = qs_r;

  // Regulator fields are register bits, so outputs stay flop-driven
  assign digital_reg_overcurrent_off_o = fast_lock_pin_control_r[FL_DIG_OCP_OFF];
  assign regs_overcurrent_off_o = regulator_settings_r[RS_REGS_OCP_OFF];
  assign reg_down_o = {regulator_settings_r[RS_DIG_DOWN], regulator_settings_r[RS_REF_DOWN],
                       regulator_settings_r[RS_RF_DOWN], regulator_settings_r[RS_OSC_DOWN],
                       regulator_settings_r[RS_HV_DOWN]};
  assign digital_reg_voltage_o = regulator_settings_r[RS_DIG_V_HI:RS_DIG_V_LO];
  assign refclk_reg_voltage_o = regulator_settings_r[RS_REF_V_HI:RS_REF_V_LO];
  assign rfout_reg_voltage_o = regulator_settings_r[RS_RF_V_HI:RS_RF_V_LO];
  assign osc_bias_reg_voltage_o = regulator_settings_r[RS_OSC_V_HI:RS_OSC_V_LO];
  assign high_volt_reg_voltage_o = regulator_settings_r[RS_HV_V_HI:RS_HV_V_LO];
  assign test_init_o = test_init_reserved_r;
endmodule

/* verification/sacr_regs_properties.sv */
// Checker: timing relations at the ports of the auxiliary register bank.
// Assumes it is bound to sacr_regs and sees only that module's ports.
`timescale 1ns/1ns
module sacr_regs_checker (
  // Clock and reset
  input logic mclk_i,
  input logic rstn_i,
  // Inputs watched
  input logic ser_load_i,
  input logic pfd_tick_i,
  input logic quick_settle_start_i,
  input logic [4:0] normal_pump_current_i,
  input logic out1_down_pin_i,
  // Outputs watched
  input logic lock_serial_out_pin_o,
  input logic lock_serial_out_pin_oe_o,
  input logic lock_pin_push_pull_o,
  input logic out1_down_o,
  input logic out2_down_o,
  input logic filter_switch_o,
  input logic cycle_slip_on_o,
  input logic [4:0] pump_current_o,
  input logic quick_settle_active_o,
  input logic [26:0] test_init_o
);
  logic [2:0] since_load_r;
  logic load_d_r;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Saturating age of the last commit edge
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      since_load_r <= 3'h7;
      load_d_r <= 1'b1;
    end else begin
      load_d_r <= ser_load_i;
      if (ser_load_i && !load_d_r) since_load_r <= 3'h0;
      else if (since_load_r != 3'h7) since_load_r <= since_load_r + 3'h1;
    end
  end
  // Slot flag and pump are both registered from slot_active in the same cycle; only inner cycles count
  sequence s_idle3;
    (rstn_i && !quick_settle_active_o)[*3];
  endsequence
  sequence s_busy3;
    quick_settle_active_o[*3];
  endsequence
  AST_PUMP_NORMAL: assert property (s_idle3 |-> $past(pump_current_o) ==
    $past(normal_pump_current_i, 2)) else $error("pump current not normal outside slot");
  AST_PUMP_HOLD: assert property (s_busy3 |->
    $past(pump_current_o) == $past(pump_current_o, 2)) else $error("pump current moved in slot");
  AST_CFG_AFTER_LOAD: assert property ($changed({cycle_slip_on_o, lock_pin_push_pull_o,
    test_init_o}) |-> since_load_r <= 3'h5) else $error("config output moved without a write");
  AST_SLOT_START: assert property ($rose(quick_settle_active_o) |->
    $past(quick_settle_start_i) || $past(quick_settle_start_i, 2) ||
    $past(quick_settle_start_i, 3)) else $error("slot began without start pulse");
  AST_SLOT_END: assert property ($fell(quick_settle_active_o) |->
    $past(pfd_tick_i) || $past(pfd_tick_i, 2) || $past(pfd_tick_i, 3))
    else $error("slot ended without a tick");
  AST_FILTER_IN_SLOT: assert property (filter_switch_o |->
    ##[0:1] (quick_settle_active_o || $past(quick_settle_active_o)))
    else $error("filter switch outside slot");
  AST_OUT2_QUICK: assert property (filter_switch_o && !out1_down_o |-> !out2_down_o)
    else $error("out2 down during quick settle");
  AST_OUT1_PIN: assert property ($past(rstn_i) |-> out1_down_o == $past(out1_down_pin_i))
    else $error("out1 down does not follow pin");
  AST_OPEN_DRAIN: assert property ((!lock_pin_push_pull_o)[*3] ##0 lock_serial_out_pin_oe_o
    |-> !lock_serial_out_pin_o) else $error("open drain pin drove high");
endmodule
bind sacr_regs sacr_regs_checker chk (.mclk_i, .rstn_i, .ser_load_i, .pfd_tick_i,
  .quick_settle_start_i, .normal_pump_current_i, .out1_down_pin_i, .lock_serial_out_pin_o,
  .lock_serial_out_pin_oe_o, .lock_pin_push_pull_o, .out1_down_o, .out2_down_o,
  .filter_switch_o, .cycle_slip_on_o, .pump_current_o, .quick_settle_active_o, .test_init_o);

/* verification/sacr_host_model.sv */
// Serial host model: sends 32-bit frames and reads the lock/data pin.
// Assumes the design samples the serial pins on mclk_i.
`timescale 1ns/1ns
module sacr_host_model (
  // Clock
  input wire logic mclk_i,
  // Serial port
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_load_o,
  // Lock / serial-out pin
  input wire logic pin_out_i,
  input wire logic pin_oe_i
);
  logic pin_level;
  // Board pull-up; open drain and hi-z read high
  assign pin_level = pin_oe_i ? pin_out_i : 1'b1;
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_load_o = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // MSB first; low phase of 3 lets read data settle before sampling
  task automatic xfer(input logic rd, input logic [3:0] addr, input logic [26:0] wdata,
                      output logic [26:0] rdata);
    logic [31:0] word;
    word = {rd, addr, wdata};
    rdata = 27'h0;
    ser_load_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      ser_data_o = word[i];
      step(3);
      if (i < 27) rdata[i] = pin_level;
      ser_clk_o = 1'b1;
      step(2);
      ser_clk_o = 1'b0;
    end
    step(2);
    ser_load_o = 1'b1;
    // Released line shows no stale bit
    ser_data_o = ~ser_data_o;
    step(5);
  endtask
endmodule

/* verification/tb_top.sv */
// Testbench for the auxiliary configuration register bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
module tb_top;
  import sacr_pkg::*;
  logic mclk_i, rstn_i, ser_clk_i, ser_data_i, ser_load_i;
  logic lock_serial_out_pin_o, lock_serial_out_pin_oe_o, lock_pin_push_pull_o;
  logic lock_det_i, loop_div_i, cal_div_i, pfd_tick_i, quick_settle_start_i;
  logic [4:0] normal_pump_current_i, reg_startup_i, reg_overcurrent_i, vco_word_i;
  logic [1:0] vco_sel_i;
  logic out1_down_pin_i, out2_down_or_filter_switch_pin_i, out1_down_o, out2_down_o;
  logic filter_switch_o, cycle_slip_on_o, quick_settle_active_o;
  logic digital_reg_overcurrent_off_o, regs_overcurrent_off_o;
  logic [4:0] pump_current_o, reg_down_o;
  logic [1:0] digital_reg_voltage_o, refclk_reg_voltage_o, rfout_reg_voltage_o;
  logic [1:0] osc_bias_reg_voltage_o, high_volt_reg_voltage_o;
  logic [26:0] test_init_o;
  int num_errors = 0;
  int total_checks = 0;
  // Push-pull, slip on, quick on, pump 31, slot of 2 cycles
  localparam logic [26:0] FL_BASE = 27'h10FE002;
  sacr_regs uut (.mclk_i, .rstn_i, .ser_clk_i, .ser_data_i, .ser_load_i,
    .lock_serial_out_pin_o, .lock_serial_out_pin_oe_o, .lock_pin_push_pull_o, .lock_det_i,
    .loop_div_i, .cal_div_i, .pfd_tick_i, .quick_settle_start_i, .normal_pump_current_i,
    .reg_startup_i, .reg_overcurrent_i, .vco_sel_i, .vco_word_i, .out1_down_pin_i,
    .out2_down_or_filter_switch_pin_i, .out1_down_o, .out2_down_o, .filter_switch_o,
    .cycle_slip_on_o, .pump_current_o, .quick_settle_active_o, .digital_reg_overcurrent_off_o,
    .regs_overcurrent_off_o, .reg_down_o, .digital_reg_voltage_o, .refclk_reg_voltage_o,
    .rfout_reg_voltage_o, .osc_bias_reg_voltage_o, .high_volt_reg_voltage_o, .test_init_o);
  sacr_host_model host (.mclk_i, .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
    .ser_load_o(ser_load_i), .pin_out_i(lock_serial_out_pin_o),
    .pin_oe_i(lock_serial_out_pin_oe_o));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [26:0] seen, input logic [26:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [26:0] d);
    logic [26:0] r;
    host.xfer(1'b0, a, d, r);
  endtask
  task automatic rdchk(input string what, input logic [3:0] a, input logic [26:0] exp);
    logic [26:0] r;
    host.xfer(1'b1, a, 27'h0, r);
    check(what, r, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(3);
  endtask
  task automatic t_reset;
    // Open drain with lock low pulls the pin, so enable is up
    check("reset outs", {cycle_slip_on_o, lock_serial_out_pin_oe_o, reg_down_o}, 27'h20);
    wr(4'hC, 27'h5A5A5A5);
    wr(ADDR_STATUS, 27'h7FFFFFF);
    rdchk("fl", ADDR_FAST_LOCK_PIN, 27'h0);
    rdchk("rs", ADDR_REG_SETTINGS, 27'h0);
    rdchk("unmapped", 4'hC, 27'h0);
    lock_det_i = 1'b1;
    reg_startup_i = 5'h16;
    reg_overcurrent_i = 5'h0B;
    vco_sel_i = 2'h2;
    vco_word_i = 5'h13;
    rdchk("status", ADDR_STATUS, {9'h0, 5'h16, 5'h0B, 1'b1, 2'h2, 5'h13});
    $display("t_reset done");
  endtask
  task automatic t_regs;
    logic [26:0] d;
    out2_down_or_filter_switch_pin_i = 1'b1;
    step(3);
    check("out2 pin", out2_down_o, 27'h1);
    for (int c = 0; c < 4; c++) begin
      d = {1'b1, 8'h0, c[1:0], 2'b0, c[1:0], 2'b0, c[1:0], 2'b0, c[1:0], 2'b0, c[1:0]};
      wr(ADDR_REG_SETTINGS, d);
      check("volts", {digital_reg_voltage_o, refclk_reg_voltage_o, rfout_reg_voltage_o,
        osc_bias_reg_voltage_o, high_volt_reg_voltage_o}, {5{c[1:0]}});
      rdchk("rs", ADDR_REG_SETTINGS, d);
    end
    check("downs", {reg_down_o, regs_overcurrent_off_o, out2_down_o}, 27'h0);
    out1_down_pin_i = 1'b1;
    step(3);
    check("out1 both", {out1_down_o, out2_down_o}, 27'h3);
    out1_down_pin_i = 1'b0;
    wr(ADDR_TEST_INIT, 27'h0);
    rdchk("ti", ADDR_TEST_INIT, 27'h0);
    check("ti out", test_init_o, 27'h0);
    $display("t_regs done");
  endtask
  task automatic t_pin;
    lock_det_i = 1'b0;
    wr(ADDR_FAST_LOCK_PIN, FL_BASE);
    check("slip pp", {cycle_slip_on_o, lock_pin_push_pull_o,
      digital_reg_overcurrent_off_o}, 27'h6);
    rdchk("fl", ADDR_FAST_LOCK_PIN, FL_BASE);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_FAST_LOCK_PIN, FL_BASE | {4'h0, s[1:0], 21'h0});
      lock_det_i = (s == 0);
      loop_div_i = (s == 1);
      cal_div_i = (s == 2);
      pfd_tick_i = (s == 3);
      step(3);
      check("src hi", {lock_serial_out_pin_oe_o, lock_serial_out_pin_o}, 27'h3);
      {lock_det_i, loop_div_i, cal_div_i, pfd_tick_i} = 4'h0;
      step(3);
      check("src lo", lock_serial_out_pin_o, 27'h0);
    end
    wr(ADDR_FAST_LOCK_PIN, FL_BASE | 27'h0800000);
    rdchk("read blocked", ADDR_FAST_LOCK_PIN, 27'h0);
    wr(ADDR_FAST_LOCK_PIN, 27'h3000000);
    lock_det_i = 1'b1;
    step(3);
    check("hiz", lock_serial_out_pin_oe_o, 27'h0);
    wr(ADDR_FAST_LOCK_PIN, 27'h0);
    check("od high", lock_serial_out_pin_oe_o, 27'h0);
    lock_det_i = 1'b0;
    step(3);
    check("od low", {lock_serial_out_pin_oe_o, lock_serial_out_pin_o}, 27'h2);
    pulse(quick_settle_start_i);
    check("no slot", {quick_settle_active_o, filter_switch_o}, 27'h0);
    $display("t_pin done");
  endtask
  task automatic t_slot;
    int n;
    wr(ADDR_FAST_LOCK_PIN, FL_BASE);
    normal_pump_current_i = 5'h05;
    step(3);
    check("pump normal", pump_current_o, 27'h05);
    pulse(quick_settle_start_i);
    check("pump slot", {quick_settle_active_o, filter_switch_o, pump_current_o}, 27'h7F);
    pulse(pfd_tick_i);
    check("slot mid", quick_settle_active_o, 27'h1);
    pulse(pfd_tick_i);
    n = 0;
    while (quick_settle_active_o !== 1'b0 && n < 20) begin
      step(1);
      n++;
    end
    check("slot end", n[26:0], 27'h0);
    step(2);
    check("pump back", pump_current_o, 27'h05);
    $display("t_slot done");
  endtask
  initial begin
    rstn_i = 1'b0;
    {lock_det_i, loop_div_i, cal_div_i, pfd_tick_i, quick_settle_start_i} = 5'h0;
    normal_pump_current_i = 5'h0;
    reg_startup_i = 5'h0;
    reg_overcurrent_i = 5'h0;
    vco_sel_i = 2'h0;
    vco_word_i = 5'h0;
    out1_down_pin_i = 1'b0;
    out2_down_or_filter_switch_pin_i = 1'b0;
    step(12);
    rstn_i = 1'b1;
    step(2);
    t_reset();
    t_regs();
    t_pin();
    t_slot();
    give_verdict();
  end
endmodule
